/* File: verilog/lcdcd_defs.vh */
// lcdcd_defs.vh: command codes, field positions and reset values of the lcd command decoder
// assumes inclusion by bare name from the design files
`ifndef LCDCD_DEFS_VH
`define LCDCD_DEFS_VH

// fixed command codes
`define LCDCD_CMD_DISP_OFF 8'hae
`define LCDCD_CMD_DISP_ON 8'haf
`define LCDCD_CMD_REV_OFF 8'ha6
`define LCDCD_CMD_REV_ON 8'ha7
`define LCDCD_CMD_ALL_OFF 8'ha4
`define LCDCD_CMD_ALL_ON 8'ha5
`define LCDCD_CMD_SEGDIR0 8'ha0
`define LCDCD_CMD_SEGDIR1 8'ha1
`define LCDCD_CMD_BIAS5 8'ha2
`define LCDCD_CMD_BIAS6 8'ha3
`define LCDCD_CMD_RMW 8'he0
`define LCDCD_CMD_END 8'hee
`define LCDCD_CMD_INV_CANCEL 8'he4
`define LCDCD_CMD_SWRESET 8'he2
`define LCDCD_CMD_NOP 8'he3

// prefixes: value under mask
`define LCDCD_MSK_COLHI 8'hf8
`define LCDCD_PFX_COLHI 8'h10
`define LCDCD_MSK_COLLO 8'hf0
`define LCDCD_PFX_COLLO 8'h00
`define LCDCD_MSK_START 8'hc0
`define LCDCD_PFX_START 8'h40
`define LCDCD_MSK_PAGE 8'hf0
`define LCDCD_PFX_PAGE 8'hb0
`define LCDCD_MSK_COMDIR 8'hf0
`define LCDCD_PFX_COMDIR 8'hc0
`define LCDCD_MSK_POWER 8'hf8
`define LCDCD_PFX_POWER 8'h28
`define LCDCD_MSK_RATIO 8'hf8
`define LCDCD_PFX_RATIO 8'h20
`define LCDCD_MSK_VOLUME 8'he0
`define LCDCD_PFX_VOLUME 8'h80
`define LCDCD_MSK_NLINE 8'hf0
`define LCDCD_PFX_NLINE 8'h30
`define LCDCD_MSK_TEST 8'hd0
`define LCDCD_PFX_TEST 8'hd0

// field positions
`define LCDCD_BIT_COMDIR 3
`define LCDCD_BIT_BOOST 2
`define LCDCD_BIT_REGUL 1
`define LCDCD_BIT_FOLLOW 0

// reset values
`define LCDCD_RST_RATIO 3'h0
`define LCDCD_RST_VOLUME 5'h00
`define LCDCD_RST_NLINE 4'h0
`define LCDCD_RST_COL 7'h00
`define LCDCD_RST_START 6'h00
`define LCDCD_RST_PAGE 4'h0

// fifo shape
`define LCDCD_FIFO_WIDTH 9
`define LCDCD_FIFO_DEPTH 4
`define LCDCD_FIFO_AW 2

`endif

/* File: verilog/lcdcd_fifo.v */
// lcdcd_fifo.v: small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

module lcdcd_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr_ff;
reg [AW-1:0] rd_ptr_ff;
reg [AW:0] count_ff;
wire push;
wire pop;

// full and empty come straight from the occupancy count
assign in_ready = (count_ff != DEPTH[AW:0]);
assign out_valid = (count_ff != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr_ff];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

// storage is not reset; only pointers and count carry state
always @(posedge clk)
begin
    if (push)
    begin
        mem[wr_ptr_ff] <= in_data;
    end
end

// pointers wrap naturally since depth is a power of two
always @(posedge clk)
begin
    if (!rst_n)
    begin
        wr_ptr_ff <= {AW{1'b0}};
        rd_ptr_ff <= {AW{1'b0}};
        count_ff <= {(AW+1){1'b0}};
    end
    else
    begin
        if (push)
        begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
        if (pop)
        begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
        if (push && !pop)
        begin
            count_ff <= count_ff + 1'b1;
        end
        else if (pop && !push)
        begin
            count_ff <= count_ff - 1'b1;
        end
    end
end

endmodule // lcdcd_fifo

`default_nettype wire

/* File: verilog/lcdcd_top.v */
// lcdcd_top.v: command interpreter of a small dot-matrix lcd controller
// assumes the host port is already reduced to byte strobes in this clock domain;
// the hardware reset pin is asynchronous to the clock and is synchronised here
// Functional notes
// - select high means display memory, low command
// - 0xae/0xaf turn display off/on
// - 0xa6/0xa7 choose normal or reversed rendering
// - 0xa4/0xa5 choose normal or all points lit
// - column upper 3 bits and lower 4 bits
// - load start line and page address
// - common scan direction from bit 3
// - read-modify-write: writes advance column, reads don't
// - end restores column saved at mode entry
// - resistance ratio field, 7 means external resistor
// - 5-bit contrast, value 0 lowest voltage
// - bias choice effective only with follower running
// - store inversion line count, 0 none
// - cancel returns two-frame drive, count kept
// - all-points on while display off enters power-save
// - power-save stops oscillator and supply generator
// - power-save grounds drivers, keeps state, serves host
// - software reset equals pin reset, memory kept
// - test commands entered; reset or display command clears
`timescale 1ns/1ns
`default_nettype none
`include "lcdcd_defs.vh"

module lcdcd_top (
    input wire CLOCK,
    input wire RESETN,
    input wire HW_RESET_N,
    input wire WR_VALID,
    output wire WR_READY,
    input wire CMD_DATA_SELECT,
    input wire [7:0] WR_DATA,
    input wire RD_REQ,
    output reg [7:0] RD_DATA,
    output reg RD_VALID,
    output reg [6:0] MEM_COL,
    output reg [3:0] MEM_PAGE,
    output reg MEM_WE,
    output reg [7:0] MEM_WDATA,
    output reg MEM_RE,
    input wire [7:0] MEM_RDATA,
    output reg DISPLAY_ON,
    output reg DISPLAY_REVERSE,
    output reg ALL_POINTS_ON,
    output reg SEG_REVERSE,
    output reg COM_REVERSE,
    output reg [5:0] START_LINE,
    output reg RMW_ACTIVE,
    output reg BOOSTER_ON,
    output reg REGULATOR_ON,
    output reg FOLLOWER_ON,
    output reg [2:0] REGULATOR_RESISTANCE_RATIO,
    output reg EXT_RESISTOR_MODE,
    output reg [4:0] CONTRAST,
    output reg BIAS_SIXTH,
    output reg [3:0] NLINE_COUNT,
    output reg NLINE_ENABLE,
    output reg POWER_SAVE,
    output reg OSC_ENABLE,
    output reg SUPPLY_ENABLE,
    output reg DRIVERS_GROUNDED,
    output reg TEST_MODE
);

// hardware reset pin passes two flops before use
reg hw_rst_meta_ff;
reg hw_rst_sync_ff;
// mode state
reg disp_on_ff;
reg reverse_ff;
reg all_on_ff;
reg seg_rev_ff;
reg com_rev_ff;
reg [5:0] start_ff;
reg [3:0] page_ff;
reg [6:0] col_ff;
reg [6:0] col_saved_ff;
reg rmw_ff;
reg [2:0] power_ff;
reg [2:0] ratio_ff;
reg [4:0] volume_ff;
reg bias_ff;
reg [3:0] nline_ff;
reg nline_en_ff;
reg psave_ff;
reg test_ff;
reg rd_pend_ff;

wire [8:0] fifo_out;
wire fifo_valid;
wire fifo_ready;
wire [7:0] byte_in;
wire is_cmd;
wire take;
wire init;
wire sw_reset;

// pattern match of a command against a masked prefix
function match;
    input [7:0] value;
    input [7:0] mask;
    input [7:0] prefix;
    begin
        match = ((value & mask) == prefix);
    end
endfunction

// column increments, wrapping after the last column
function [6:0] col_next;
    input [6:0] col;
    begin
        if (col == 7'h65)
        begin
            col_next = 7'h00;
        end
        else
        begin
            col_next = col + 7'h01;
        end
    end
endfunction

// fifo decouples host bursts from the decoder; reads stall it so order holds
lcdcd_fifo #(
    .WIDTH(`LCDCD_FIFO_WIDTH),
    .DEPTH(`LCDCD_FIFO_DEPTH),
    .AW(`LCDCD_FIFO_AW)
) u_fifo (
    .clk(CLOCK),
    .rst_n(RESETN),
    .in_valid(WR_VALID),
    .in_ready(WR_READY),
    .in_data({CMD_DATA_SELECT, WR_DATA}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_out)
);

assign fifo_ready = !rd_pend_ff;
assign take = fifo_valid && fifo_ready;
assign byte_in = fifo_out[7:0];
assign is_cmd = !fifo_out[8];
assign sw_reset = take && is_cmd && (byte_in == `LCDCD_CMD_SWRESET);
assign init = !hw_rst_sync_ff || sw_reset;

// reset pin synchroniser
always @(posedge CLOCK)
begin
    if (!RESETN)
    begin
        hw_rst_meta_ff <= 1'b0;
        hw_rst_sync_ff <= 1'b0;
    end
    else
    begin
        hw_rst_meta_ff <= HW_RESET_N;
        hw_rst_sync_ff <= hw_rst_meta_ff;
    end
end

// command decode and mode registers; software reset reinitialises all but memory
always @(posedge CLOCK)
begin
    if (!RESETN || init)
    begin
        disp_on_ff <= 1'b0;
        reverse_ff <= 1'b0;
        all_on_ff <= 1'b0;
        seg_rev_ff <= 1'b0;
        com_rev_ff <= 1'b0;
        start_ff <= `LCDCD_RST_START;
        page_ff <= `LCDCD_RST_PAGE;
        col_ff <= `LCDCD_RST_COL;
        col_saved_ff <= `LCDCD_RST_COL;
        rmw_ff <= 1'b0;
        power_ff <= 3'h0;
        ratio_ff <= `LCDCD_RST_RATIO;
        volume_ff <= `LCDCD_RST_VOLUME;
        bias_ff <= 1'b0;
        nline_ff <= `LCDCD_RST_NLINE;
        nline_en_ff <= 1'b0;
        psave_ff <= 1'b0;
        test_ff <= 1'b0;
    end
    else if (take && !is_cmd)
    begin
        // data write advances column, also in rmw mode
        col_ff <= col_next(col_ff);
    end
    else if (take && is_cmd)
    begin
        if (match(byte_in, 8'hfe, `LCDCD_CMD_DISP_OFF))
        begin
            disp_on_ff <= byte_in[0];
            test_ff <= 1'b0;
            if (byte_in[0])
            begin
                psave_ff <= 1'b0;
            end
            else if (all_on_ff)
            begin
                psave_ff <= 1'b1;
            end
        end
        else if (match(byte_in, 8'hfe, `LCDCD_CMD_REV_OFF))
        begin
            reverse_ff <= byte_in[0];
        end
        else if (match(byte_in, 8'hfe, `LCDCD_CMD_ALL_OFF))
        begin
            all_on_ff <= byte_in[0];
            if (!byte_in[0])
            begin
                psave_ff <= 1'b0;
            end
            else if (!disp_on_ff)
            begin
                psave_ff <= 1'b1;
            end
        end
        else if (match(byte_in, 8'hfe, `LCDCD_CMD_SEGDIR0))
        begin
            seg_rev_ff <= byte_in[0];
        end
        else if (match(byte_in, 8'hfe, `LCDCD_CMD_BIAS5))
        begin
            bias_ff <= byte_in[0];
        end
        else if (byte_in == `LCDCD_CMD_RMW)
        begin
            rmw_ff <= 1'b1;
            col_saved_ff <= col_ff;
        end
        else if (byte_in == `LCDCD_CMD_END)
        begin
            rmw_ff <= 1'b0;
            if (rmw_ff)
            begin
                col_ff <= col_saved_ff;
            end
        end
        else if (byte_in == `LCDCD_CMD_INV_CANCEL)
        begin
            nline_en_ff <= 1'b0;
        end
        else if (byte_in == `LCDCD_CMD_NOP)
        begin
            // no state changes
            nline_en_ff <= nline_en_ff;
        end
        else if (match(byte_in, `LCDCD_MSK_TEST, `LCDCD_PFX_TEST))
        begin
            test_ff <= 1'b1;
        end
        else if (match(byte_in, `LCDCD_MSK_COMDIR, `LCDCD_PFX_COMDIR))
        begin
            com_rev_ff <= byte_in[`LCDCD_BIT_COMDIR];
        end
        else if (match(byte_in, `LCDCD_MSK_PAGE, `LCDCD_PFX_PAGE))
        begin
            page_ff <= byte_in[3:0];
        end
        else if (match(byte_in, `LCDCD_MSK_VOLUME, `LCDCD_PFX_VOLUME))
        begin
            volume_ff <= byte_in[4:0];
        end
        else if (match(byte_in, `LCDCD_MSK_START, `LCDCD_PFX_START))
        begin
            start_ff <= byte_in[5:0];
        end
        else if (match(byte_in, `LCDCD_MSK_NLINE, `LCDCD_PFX_NLINE))
        begin
            nline_ff <= byte_in[3:0];
            nline_en_ff <= (byte_in[3:0] != 4'h0);
        end
        else if (match(byte_in, `LCDCD_MSK_POWER, `LCDCD_PFX_POWER))
        begin
            power_ff <= byte_in[2:0];
        end
        else if (match(byte_in, `LCDCD_MSK_RATIO, `LCDCD_PFX_RATIO))
        begin
            ratio_ff <= byte_in[2:0];
        end
        else if (match(byte_in, `LCDCD_MSK_COLHI, `LCDCD_PFX_COLHI))
        begin
            col_ff <= {byte_in[2:0], col_ff[3:0]};
        end
        else if (match(byte_in, `LCDCD_MSK_COLLO, `LCDCD_PFX_COLLO))
        begin
            col_ff <= {col_ff[6:4], byte_in[3:0]};
        end
    end
    else if (rd_pend_ff && !rmw_ff)
    begin
        // a completed read advances the column only outside rmw mode
        col_ff <= col_next(col_ff);
    end
end

// read path: a read waits for earlier queued bytes so it sees their effect
always @(posedge CLOCK)
begin
    if (!RESETN)
    begin
        rd_pend_ff <= 1'b0;
        RD_VALID <= 1'b0;
        RD_DATA <= 8'h00;
    end
    else
    begin
        RD_VALID <= 1'b0;
        if (rd_pend_ff)
        begin
            rd_pend_ff <= 1'b0;
            RD_VALID <= 1'b1;
            RD_DATA <= MEM_RDATA;
        end
        else if (RD_REQ && !fifo_valid)
        begin
            rd_pend_ff <= 1'b1;
        end
    end
end

// memory strobes: registered so data outputs come from flops
always @(posedge CLOCK)
begin
    if (!RESETN)
    begin
        MEM_WE <= 1'b0;
        MEM_RE <= 1'b0;
        MEM_WDATA <= 8'h00;
        MEM_COL <= `LCDCD_RST_COL;
        MEM_PAGE <= `LCDCD_RST_PAGE;
    end
    else
    begin
        // host access still served in power-save
        MEM_WE <= take && !is_cmd;
        MEM_RE <= RD_REQ && !fifo_valid && !rd_pend_ff;
        MEM_WDATA <= byte_in;
        MEM_COL <= col_ff;
        MEM_PAGE <= page_ff;
    end
end

// registered status outputs; power-save overrides oscillator, supply and drivers
always @(posedge CLOCK)
begin
    if (!RESETN)
    begin
        DISPLAY_ON <= 1'b0;
        DISPLAY_REVERSE <= 1'b0;
        ALL_POINTS_ON <= 1'b0;
        SEG_REVERSE <= 1'b0;
        COM_REVERSE <= 1'b0;
        START_LINE <= `LCDCD_RST_START;
        RMW_ACTIVE <= 1'b0;
        BOOSTER_ON <= 1'b0;
        REGULATOR_ON <= 1'b0;
        FOLLOWER_ON <= 1'b0;
        REGULATOR_RESISTANCE_RATIO <= `LCDCD_RST_RATIO;
        EXT_RESISTOR_MODE <= 1'b0;
        CONTRAST <= `LCDCD_RST_VOLUME;
        BIAS_SIXTH <= 1'b0;
        NLINE_COUNT <= `LCDCD_RST_NLINE;
        NLINE_ENABLE <= 1'b0;
        POWER_SAVE <= 1'b0;
        OSC_ENABLE <= 1'b1;
        SUPPLY_ENABLE <= 1'b0;
        DRIVERS_GROUNDED <= 1'b0;
        TEST_MODE <= 1'b0;
    end
    else
    begin
        DISPLAY_ON <= disp_on_ff;
        DISPLAY_REVERSE <= reverse_ff;
        ALL_POINTS_ON <= all_on_ff;
        SEG_REVERSE <= seg_rev_ff;
        COM_REVERSE <= com_rev_ff;
        START_LINE <= start_ff;
        RMW_ACTIVE <= rmw_ff;
        BOOSTER_ON <= power_ff[`LCDCD_BIT_BOOST] && !psave_ff;
        REGULATOR_ON <= power_ff[`LCDCD_BIT_REGUL] && !psave_ff;
        FOLLOWER_ON <= power_ff[`LCDCD_BIT_FOLLOW] && !psave_ff;
        REGULATOR_RESISTANCE_RATIO <= ratio_ff;
        EXT_RESISTOR_MODE <= (ratio_ff == 3'h7);
        CONTRAST <= volume_ff;
        // stored bias only reaches the drive while the follower runs
        BIAS_SIXTH <= bias_ff && power_ff[`LCDCD_BIT_FOLLOW] && !psave_ff;
        NLINE_COUNT <= nline_ff;
        NLINE_ENABLE <= nline_en_ff;
        POWER_SAVE <= psave_ff;
        OSC_ENABLE <= !psave_ff;
        SUPPLY_ENABLE <= (power_ff != 3'h0) && !psave_ff;
        DRIVERS_GROUNDED <= psave_ff;
        TEST_MODE <= test_ff;
    end
end

endmodule // lcdcd_top

`default_nettype wire

/* File: test/lcdcd_sva.sv */
// lcdcd_sva.sv: port checks of the lcd command decoder, bound into lcdcd_top
// assumes one clock and the synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module lcdcd_sva (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic RD_VALID,
    input wire logic MEM_RE,
    input wire logic [6:0] MEM_COL,
    input wire logic DISPLAY_ON,
    input wire logic ALL_POINTS_ON,
    input wire logic RMW_ACTIVE,
    input wire logic BOOSTER_ON,
    input wire logic FOLLOWER_ON,
    input wire logic [2:0] REGULATOR_RESISTANCE_RATIO,
    input wire logic EXT_RESISTOR_MODE,
    input wire logic BIAS_SIXTH,
    input wire logic POWER_SAVE,
    input wire logic OSC_ENABLE,
    input wire logic SUPPLY_ENABLE,
    input wire logic DRIVERS_GROUNDED,
    input wire logic TEST_MODE
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);
    // reads: one answer pulse shortly after the memory strobe
    a_rd_answer: assert property (MEM_RE |-> ##[1:2] RD_VALID)
        else $error("read strobe without answer");
    a_rd_pulse: assert property (RD_VALID |=> !RD_VALID)
        else $error("read answer longer than one cycle");
    // a read in read-modify-write must not move the column
    a_rmw_col_hold: assert property (RMW_ACTIVE && MEM_RE |-> $stable(MEM_COL) [*4])
        else $error("column moved on a rmw read");
    // two settled cycles of the field; flag and field are registered in the same cycle
    a_ratio_ext: assert property (
        $stable(REGULATOR_RESISTANCE_RATIO) && $past(REGULATOR_RESISTANCE_RATIO, 2) == REGULATOR_RESISTANCE_RATIO
        |-> EXT_RESISTOR_MODE == (REGULATOR_RESISTANCE_RATIO == 3'h7))
        else $error("external resistor flag wrong");
    a_bias_follow: assert property (BIAS_SIXTH |-> FOLLOWER_ON && !POWER_SAVE)
        else $error("bias active without follower");
    // power save entry, effects and exit
    a_psave_enter: assert property ($rose(POWER_SAVE) |-> ALL_POINTS_ON && !DISPLAY_ON)
        else $error("power save entered without cause");
    a_psave_stop: assert property (POWER_SAVE && $past(POWER_SAVE) |-> !OSC_ENABLE && !SUPPLY_ENABLE)
        else $error("oscillator or supply running in power save");
    a_psave_ground: assert property (POWER_SAVE && $past(POWER_SAVE) |-> DRIVERS_GROUNDED && !BOOSTER_ON)
        else $error("drivers not grounded in power save");
    a_psave_leave: assert property ($fell(POWER_SAVE) |-> DISPLAY_ON || !ALL_POINTS_ON)
        else $error("power save left without cause");
    a_test_clear: assert property ($changed(DISPLAY_ON) |-> ##[0:1] !TEST_MODE)
        else $error("display command left test mode set");
    c_psave: cover property ($rose(POWER_SAVE));
    c_rmw_read: cover property (RMW_ACTIVE && MEM_RE);
    c_test_clear: cover property ($fell(TEST_MODE));
endmodule // lcdcd_sva

bind lcdcd_top lcdcd_sva u_lcdcd_sva (
    .CLOCK, .RESETN, .RD_VALID, .MEM_RE, .MEM_COL, .DISPLAY_ON, .ALL_POINTS_ON, .RMW_ACTIVE,
    .BOOSTER_ON, .FOLLOWER_ON, .REGULATOR_RESISTANCE_RATIO, .EXT_RESISTOR_MODE, .BIAS_SIXTH,
    .POWER_SAVE, .OSC_ENABLE, .SUPPLY_ENABLE, .DRIVERS_GROUNDED, .TEST_MODE
);
`default_nettype wire

/* File: test/lcdcd_mem_model.sv */
// lcdcd_mem_model.sv: display memory behind the decoder's memory port
// assumes the byte is taken during or one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module lcdcd_mem_model (
    input wire logic clk,
    input wire logic [6:0] col,
    input wire logic [3:0] page,
    input wire logic we,
    input wire logic [7:0] wdata,
    input wire logic re,
    output logic [7:0] rdata
);
    logic [7:0] mem_ff [0:2047];
    logic [7:0] hold_ff = 8'h00;
    logic [7:0] junk_ff = 8'h00;
    logic vld_ff = 1'b0;
    // store writes, latch the read byte; a moving pattern off the read slot exposes late sampling
    always @(posedge clk)
    begin
        if (we)
            mem_ff[{page, col}] <= wdata;
        if (re)
            hold_ff <= mem_ff[{page, col}];
        vld_ff <= re;
        junk_ff <= junk_ff + 8'h35;
    end
    assign rdata = re ? mem_ff[{page, col}] : (vld_ff ? hold_ff : junk_ff);
endmodule // lcdcd_mem_model
`default_nettype wire

/* File: test/tb_top.sv */
// tb_top.sv: self-checking bench for the lcd command decoder
// assumes lcdcd_top, the memory model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hw_n = 1'b0;
    logic wr_v = 1'b0;
    logic sel = 1'b0;
    logic rd_req = 1'b0;
    logic [7:0] wr_d = 8'h00;
    logic wr_rdy, rd_v, we, re, don, drev, apo, segr, comr, rmw;
    logic boost, regon, fol, ext, b6, ne, ps, osc, sup, gnd, tm;
    logic [7:0] rd_d, wd, rdat;
    logic [6:0] col;
    logic [5:0] sl;
    logic [4:0] con;
    logic [3:0] page, nc;
    logic [2:0] ratio;
    logic [151:0] st;
    int n_fail = 0;
    int n_tests = 0;
    // observed levels except segr, boost, regon and fol, one byte each, index 0 at the bottom
    assign st = {8'(tm), 8'(b6), 8'(gnd), 8'(sup), 8'(osc), 8'(ps), 8'(rmw), 8'(col), 8'(page), 8'(ne),
        8'(nc), 8'(con), 8'(ext), 8'(ratio), 8'(sl), 8'(comr), 8'(apo), 8'(drev), 8'(don)};
    // 125 MHz
    always #4 clk = ~clk;
    lcdcd_top u_lcdcd_top (.CLOCK(clk), .RESETN(rst_n), .HW_RESET_N(hw_n), .WR_VALID(wr_v),
        .WR_READY(wr_rdy), .CMD_DATA_SELECT(sel), .WR_DATA(wr_d), .RD_REQ(rd_req), .RD_DATA(rd_d),
        .RD_VALID(rd_v), .MEM_COL(col), .MEM_PAGE(page), .MEM_WE(we), .MEM_WDATA(wd), .MEM_RE(re),
        .MEM_RDATA(rdat), .DISPLAY_ON(don), .DISPLAY_REVERSE(drev), .ALL_POINTS_ON(apo),
        .SEG_REVERSE(segr), .COM_REVERSE(comr), .START_LINE(sl), .RMW_ACTIVE(rmw), .BOOSTER_ON(boost),
        .REGULATOR_ON(regon), .FOLLOWER_ON(fol), .REGULATOR_RESISTANCE_RATIO(ratio),
        .EXT_RESISTOR_MODE(ext), .CONTRAST(con), .BIAS_SIXTH(b6), .NLINE_COUNT(nc), .NLINE_ENABLE(ne),
        .POWER_SAVE(ps), .OSC_ENABLE(osc), .SUPPLY_ENABLE(sup), .DRIVERS_GROUNDED(gnd), .TEST_MODE(tm));
    lcdcd_mem_model u_lcdcd_mem_model (.clk(clk), .col(col), .page(page), .we(we), .wdata(wd),
        .re(re), .rdata(rdat));
    function automatic logic [7:0] view(input int k);
        return st[k*8 +: 8];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // one byte through the write handshake, held until taken
    task automatic put(input logic s, input logic [7:0] b);
        @(posedge clk) #1 wr_v = 1'b1;
        sel = s;
        wr_d = b;
        while (wr_rdy !== 1'b1)
            #8;
        @(posedge clk) #1 wr_v = 1'b0;
    endtask
    // command byte, then the settled view of one output (k below 0: none)
    task automatic mc(input logic [7:0] b, input int k, input logic [7:0] exp);
        put(1'b0, b);
        repeat (4) @(posedge clk);
        if (k >= 0)
            #1 chk(view(k), exp);
    endtask
    // read request on an idle port; the one-cycle answer follows the edge after the taking edge
    task automatic rd_chk(input logic [7:0] exp);
        @(posedge clk) #1 rd_req = 1'b1;
        @(posedge clk) #1 rd_req = 1'b0;
        @(posedge clk);
        #1 chk(8'(rd_v), 8'h01);
        chk(rd_d, exp);
    endtask
    task automatic t_modes;
        mc(8'haf, 0, 8'h01);
        mc(8'ha7, 1, 8'h01);
        mc(8'ha6, 1, 8'h00);
        mc(8'ha5, 2, 8'h01);
        mc(8'ha4, 2, 8'h00);
        mc(8'hcf, 3, 8'h01);
        mc(8'hc7, 3, 8'h00);
        mc(8'ha1, -1, 8'h00);
        mc(8'he3, -1, 8'h00);
        chk(8'(segr), 8'h01);
        mc(8'h7f, 4, 8'h3f);
        mc(8'h25, 5, 8'h05);
        mc(8'h27, 6, 8'h01);
        mc(8'h80, 7, 8'h00);
        mc(8'h9f, 7, 8'h1f);
        mc(8'h3f, 8, 8'h0f);
        mc(8'he4, 9, 8'h00);
        mc(8'he3, 8, 8'h0f);
        mc(8'h31, 8, 8'h01);
        mc(8'h30, 9, 8'h00);
        mc(8'hb6, 10, 8'h06);
        mc(8'hae, 0, 8'h00);
    endtask
    task automatic t_mem;
        mc(8'hb3, 10, 8'h03);
        mc(8'h12, -1, 8'h00);
        mc(8'h05, 11, 8'h25);
        put(1'b1, 8'h3c);
        put(1'b1, 8'hc3);
        mc(8'he3, 11, 8'h27);
        mc(8'h02, 11, 8'h22);
        mc(8'h05, 11, 8'h25);
        rd_chk(8'h3c);
        rd_chk(8'hc3);
        mc(8'h16, -1, 8'h00);
        mc(8'h05, 11, 8'h65);
        put(1'b1, 8'h77);
        mc(8'he3, 11, 8'h00);
    endtask
    task automatic t_rmw;
        mc(8'h12, -1, 8'h00);
        mc(8'h05, 11, 8'h25);
        mc(8'he0, 12, 8'h01);
        rd_chk(8'h3c);
        mc(8'he3, 11, 8'h25);
        put(1'b1, 8'h11);
        mc(8'he3, 11, 8'h26);
        mc(8'hee, 11, 8'h25);
        chk(view(12), 8'h00);
        rd_chk(8'h11);
    endtask
    task automatic t_psave;
        mc(8'h2f, 15, 8'h01);
        mc(8'ha3, 17, 8'h01);
        mc(8'h2e, 17, 8'h00);
        chk({5'h00, boost, regon, fol}, 8'h06);
        mc(8'h2f, 17, 8'h01);
        mc(8'hae, -1, 8'h00);
        mc(8'ha5, 13, 8'h01);
        chk(view(14), 8'h00);
        chk(view(15), 8'h00);
        chk(view(16), 8'h01);
        chk({5'h00, boost, regon, fol}, 8'h00);
        chk(view(7), 8'h1f);
        mc(8'h05, 11, 8'h25);
        rd_chk(8'h11);
        mc(8'ha4, 13, 8'h00);
        chk(view(14), 8'h01);
        mc(8'ha5, 13, 8'h01);
        mc(8'haf, 13, 8'h00);
        chk(view(17), 8'h01);
        chk({5'h00, boost, regon, fol}, 8'h07);
        mc(8'ha4, 2, 8'h00);
    endtask
    task automatic t_test;
        mc(8'hd0, 18, 8'h01);
        mc(8'hae, 18, 8'h00);
        mc(8'hf5, 18, 8'h01);
        mc(8'he2, 18, 8'h00);
        mc(8'hdf, 18, 8'h01);
        mc(8'ha5, 13, 8'h01);
        @(posedge clk) #1 hw_n = 1'b0;
        repeat (4) @(posedge clk);
        #1 hw_n = 1'b1;
        repeat (4) @(posedge clk);
        #1 chk(view(18), 8'h00);
        chk(view(13), 8'h00);
    endtask
    task automatic t_swrst;
        mc(8'haf, 0, 8'h01);
        mc(8'h9a, 7, 8'h1a);
        mc(8'he2, 0, 8'h00);
        chk(view(7), 8'h00);
        chk(view(14), 8'h01);
        mc(8'h9a, 7, 8'h1a);
        mc(8'hb3, -1, 8'h00);
        mc(8'h12, -1, 8'h00);
        mc(8'h05, 11, 8'h25);
        rd_chk(8'h11);
    endtask
    task automatic end_sim;
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, far above the roughly 400 cycles the run needs
    initial
    begin
        repeat (8000) @(posedge clk);
        n_fail++;
        end_sim();
    end
    // reset, then the scenarios in turn
    initial
    begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        hw_n = 1'b1;
        t_modes();
        t_mem();
        t_rmw();
        t_psave();
        t_test();
        t_swrst();
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
